// *** core/thermal_throttle_monitor.sv ***
// thermal throttle monitor: throttle control, alert and catastrophic trip
`timescale 1ns/1ps
`include "thermal_throttle_regs.svh"

// Function
// - auto throttling off until enable set
// - auto activates only near temperature limit
// - active unit alternately stops core clocks
// - modulation period scales with core frequency
// - cool die ends modulation, unit inactive
// - trip has hysteresis against rapid toggling
// - auto duty is fixed constant
// - on-demand bit activates unit immediately
// - control bits select on-fraction in eighths
// - hot auto mode overrides programmed duty
// - alert pin low at thermal limit
// - unit active while hot only with auto enable set; alert alone does not activate it
// - trip point fixed and invisible
// - snoops and interrupts unaffected by throttling
// - interrupt on alert assert and deassert
// - shutdown at catastrophic temperature regardless
// - catastrophic trip held until reset
// - trip independent of processor activity
module thermal_throttle_monitor
  import thermal_throttle_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic                    sensor_hot,
  input  wire logic                    sensor_catastrophic,
  input  wire logic                    auto_enable,
  input  wire logic [`TT_CTRL_W-1:0]   thermal_ctrl,
  input  wire logic                    alert_irq_enable,
  input  wire logic [`TT_PERIOD_W-1:0] period_step_cycles,
  output logic                         core_clk_enable,
  output logic                         throttle_active,
  output logic                         thermal_limit_alert_n,
  output logic                         alert_irq,
  output logic                         catastrophic_trip_n,
  output logic                         snoop_service_enable
);
  throttle_state_t         state_q, state_d;
  logic [`TT_HYST_W-1:0]   hyst_q;
  logic                    hot_q;
  logic                    alert_q;
  logic                    irq_q;
  logic                    trip_q;
  logic                    ondemand;
  logic [`TT_DUTY_W-1:0]   prog_duty;
  logic                    auto_hot;
  logic                    run;
  logic [`TT_DUTY_W-1:0]   duty_sel;
  logic                    clk_on;

  // ==========================================================
  // activation decode
  // trip point lives in the sensor; nothing here can set or read it
  assign ondemand  = thermal_ctrl[`TT_CTRL_ODM_BIT];
  assign prog_duty = thermal_ctrl[`TT_CTRL_DUTY_HI:`TT_CTRL_DUTY_LO];
  assign auto_hot  = auto_enable && hot_q;
  assign run       = auto_hot || ondemand;
  // reserved code 0 falls back to the fixed auto duty, never a dead stop
  assign duty_sel  = (auto_hot || prog_duty == '0) ? `TT_AUTO_DUTY
                                                   : prog_duty;

  // ==========================================================
  // hysteresis: hot clears only after sensor stays cool a while
  always_comb begin
    state_d = state_q;
    case (state_q)
      TT_IDLE:   if (sensor_hot) state_d = TT_ACTIVE;
      TT_ACTIVE: if (!sensor_hot) state_d = TT_COOL;
      TT_COOL: begin
        if (sensor_hot) state_d = TT_ACTIVE;
        else if (hyst_q == `TT_HYST_W'(`TT_HYST_CYCLES - 1)) state_d = TT_IDLE;
      end
      default:   state_d = TT_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= TT_IDLE;
      hyst_q  <= '0;
      hot_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      hyst_q  <= (state_q == TT_COOL && !sensor_hot) ? hyst_q + 1'b1 : '0;
      hot_q   <= (state_d != TT_IDLE);
    end
  end

  // ==========================================================
  // clock modulation
  duty_modulator u_mod (
    .clk         (clk),
    .resetn      (resetn),
    .run         (run),
    .duty        (duty_sel),
    .step_cycles (period_step_cycles),
    .clk_on      (clk_on)
  );

  assign core_clk_enable = clk_on;
  assign throttle_active = run;
  // snoop and interrupt latch logic never sees the gate
  assign snoop_service_enable = 1'b1;

  // ==========================================================
  // alert pin, edge interrupt, catastrophic trip
  always_ff @(posedge clk) begin
    if (!resetn) begin
      alert_q <= 1'b0;
      irq_q   <= 1'b0;
      trip_q  <= 1'b0;
    end else begin
      alert_q <= hot_q;
      irq_q   <= alert_irq_enable && (alert_q != hot_q);
      // sticky: only the reset branch clears it
      trip_q  <= trip_q || sensor_catastrophic;
    end
  end

  assign thermal_limit_alert_n = !alert_q;
  assign alert_irq             = irq_q;
  assign catastrophic_trip_n   = !trip_q;

  // ==========================================================
  // checks
  a_trip_sticky: assert property (@(posedge clk) disable iff (!resetn)
    !catastrophic_trip_n |=> !catastrophic_trip_n)
    else $error("catastrophic trip released without reset");
  a_trip_sets: assert property (@(posedge clk) disable iff (!resetn)
    sensor_catastrophic |=> !catastrophic_trip_n)
    else $error("catastrophic trip not raised");
  a_auto_gated: assert property (@(posedge clk) disable iff (!resetn)
    (!auto_enable && !thermal_ctrl[`TT_CTRL_ODM_BIT]) |-> !throttle_active)
    else $error("throttle active without any enable");
  a_ondemand_now: assert property (@(posedge clk) disable iff (!resetn)
    thermal_ctrl[`TT_CTRL_ODM_BIT] |-> throttle_active)
    else $error("on-demand did not activate throttle");
  a_alert_follow: assert property (@(posedge clk) disable iff (!resetn)
    $rose(hot_q) |=> !thermal_limit_alert_n)
    else $error("alert not asserted when hot");
  a_alert_active: assert property (@(posedge clk) disable iff (!resetn)
    (!thermal_limit_alert_n && auto_enable && hot_q) |-> throttle_active)
    else $error("throttle idle while alert asserted");
  a_irq_edges: assert property (@(posedge clk) disable iff (!resetn)
    (alert_irq_enable && $changed(thermal_limit_alert_n)) |-> alert_irq)
    else $error("alert edge missed interrupt");
  // hot may only clear on the last cool cycle of the hold count
  a_hyst_hold: assert property (@(posedge clk) disable iff (!resetn)
    (hot_q && !sensor_hot && !(state_q == TT_COOL
      && hyst_q == `TT_HYST_W'(`TT_HYST_CYCLES - 1))) |=> hot_q)
    else $error("hot cleared without hysteresis");
  a_alert_clear: assert property (@(posedge clk) disable iff (!resetn)
    $fell(hot_q) |=> thermal_limit_alert_n)
    else $error("alert held after die cooled");
  a_prog_duty: assert property (@(posedge clk) disable iff (!resetn)
    (ondemand && !auto_hot && prog_duty != '0) |-> duty_sel == prog_duty)
    else $error("programmed duty not used");
  a_code_zero: assert property (@(posedge clk) disable iff (!resetn)
    (ondemand && prog_duty == '0) |-> duty_sel == `TT_AUTO_DUTY)
    else $error("reserved duty code not mapped");
  a_ondemand_off: assert property (@(posedge clk) disable iff (!resetn)
    (!thermal_ctrl[`TT_CTRL_ODM_BIT] && !(auto_enable && hot_q)) |-> !throttle_active)
    else $error("throttle stayed on after on-demand cleared");
  a_snoop_kept: assert property (@(posedge clk) disable iff (!resetn)
    throttle_active |-> snoop_service_enable)
    else $error("snoop service dropped while throttling");
  a_idle_clock: assert property (@(posedge clk) disable iff (!resetn)
    (!throttle_active) [*2] |-> core_clk_enable)
    else $error("clocks gated while inactive");
  a_auto_override: assert property (@(posedge clk) disable iff (!resetn)
    auto_hot |-> duty_sel == `TT_AUTO_DUTY)
    else $error("auto duty not used while hot");
endmodule : thermal_throttle_monitor

// *** core/thermal_throttle_regs.svh ***
// constants for the thermal throttle monitor
`ifndef THERMAL_THROTTLE_REGS_SVH
`define THERMAL_THROTTLE_REGS_SVH

// ==========================================================
// duty and period
`define TT_DUTY_W        3
`define TT_AUTO_DUTY     3'h3
`define TT_PERIOD_W      8
// on-demand control word fields
`define TT_CTRL_W        5
`define TT_CTRL_ODM_BIT  4
`define TT_CTRL_DUTY_HI  3
`define TT_CTRL_DUTY_LO  1
`define TT_CTRL_RESET    5'h00
// hysteresis hold in cycles
`define TT_HYST_NS       64
`define TT_CLK_NS        8
`define TT_HYST_CYCLES   ((`TT_HYST_NS + `TT_CLK_NS - 1) / `TT_CLK_NS)
`define TT_HYST_W        4

`endif

// *** core/thermal_throttle_pkg.sv ***
// types for the thermal throttle monitor
package thermal_throttle_pkg;
  typedef enum logic [1:0] {
    TT_IDLE   = 2'b00,
    TT_ACTIVE = 2'b01,
    TT_COOL   = 2'b11
  } throttle_state_t;
endpackage : thermal_throttle_pkg

// *** core/duty_modulator.sv ***
// on/off clock gate generator for k eighths duty
`timescale 1ns/1ps
`include "thermal_throttle_regs.svh"

module duty_modulator (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic                    run,
  input  wire logic [`TT_DUTY_W-1:0]   duty,
  input  wire logic [`TT_PERIOD_W-1:0] step_cycles,
  output logic                         clk_on
);
  logic [`TT_PERIOD_W-1:0] div_q;
  logic [2:0]              eighth_q;
  logic                    step;
  logic                    on_d;
  logic                    clk_on_q;

  // ==========================================================
  // period = 8 * (step_cycles + 1) core clocks, so it tracks core frequency
  assign step = (div_q == step_cycles) || (step_cycles == '0);
  assign on_d = run ? (eighth_q < duty) : 1'b1;

  always_ff @(posedge clk) begin
    if (!resetn || !run) begin
      div_q    <= '0;
      eighth_q <= '0;
    end else if (step) begin
      div_q    <= '0;
      eighth_q <= eighth_q + 3'h1;
    end else begin
      div_q    <= div_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      clk_on_q <= 1'b1;
    end else begin
      clk_on_q <= on_d;
    end
  end

  assign clk_on = clk_on_q;
endmodule : duty_modulator

// *** dv/board_watch.sv ***
// board-side model counting alert edges and interrupt pulses
`timescale 1ns/1ps
module board_watch (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       alert_n,
  input  wire logic       irq,
  output logic      [7:0] edge_count,
  output logic      [7:0] irq_count
);
  logic alert_q;
  always_ff @(posedge clk) begin
    alert_q <= alert_n;
    if (!resetn) begin
      edge_count <= 8'h00;
      irq_count  <= 8'h00;
    end else begin
      if (alert_q !== alert_n) edge_count <= edge_count + 8'h01;
      if (irq) irq_count <= irq_count + 8'h01;
    end
  end
endmodule : board_watch

// *** dv/tb.sv ***
// self-checking bench for the thermal throttle monitor
`timescale 1ns/1ps
module tb import thermal_throttle_pkg::*;;
  logic       clk = 1'b0, resetn = 1'b0, hot = 1'b0, cat = 1'b0, auto_en = 1'b0;
  logic [4:0] ctrl = 5'h00;
  logic [7:0] step = 8'h00, edges, irqs, on, rises;
  logic       clk_en, active, alert_n, irq, trip_n, snoop;
  logic       irq_en = 1'b1;
  int         num_errors = 0, check_count = 0;
  typedef struct {logic a, h, s; logic [4:0] c; logic [7:0] on; logic act;} row_t;
  // cold on-demand codes, reserved code, auto override, auto off, longer eighths
  row_t rows [11] = '{'{0,0,0,5'h12,8'h08,1}, '{0,0,0,5'h14,8'h10,1},
    '{0,0,0,5'h16,8'h18,1}, '{0,0,0,5'h18,8'h20,1}, '{0,0,0,5'h1a,8'h28,1},
    '{0,0,0,5'h1c,8'h30,1}, '{0,0,0,5'h1e,8'h38,1}, '{0,0,0,5'h10,8'h18,1},
    '{1,1,0,5'h1e,8'h18,1}, '{0,1,0,5'h00,8'h40,0}, '{0,0,1,5'h14,8'h10,1}};
  always #4 clk = ~clk;
  thermal_throttle_monitor DUT (.clk(clk), .resetn(resetn), .sensor_hot(hot),
    .sensor_catastrophic(cat), .auto_enable(auto_en), .thermal_ctrl(ctrl),
    .alert_irq_enable(irq_en), .period_step_cycles(step), .core_clk_enable(clk_en),
    .throttle_active(active), .thermal_limit_alert_n(alert_n), .alert_irq(irq),
    .catastrophic_trip_n(trip_n), .snoop_service_enable(snoop));
  board_watch watch (.clk(clk), .resetn(resetn), .alert_n(alert_n), .irq(irq),
    .edge_count(edges), .irq_count(irqs));
  task automatic check(input string what, input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic results();
    if (num_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  // window of 64 cycles is a whole number of periods for both step values
  task automatic measure();
    logic p;
    p = clk_en;
    on = 8'h00;
    rises = 8'h00;
    repeat (64) begin
      @(negedge clk);
      on = on + 8'(clk_en);
      rises = rises + 8'(clk_en & ~p);
      p = clk_en;
    end
  endtask : measure
  initial begin
    #20us;
    num_errors++;
    results();
  end
  // ==========================================
  // stimulus
  initial begin
    cyc(8);
    resetn = 1'b1;
    foreach (rows[i]) begin
      auto_en = rows[i].a;
      hot = rows[i].h;
      ctrl = rows[i].c;
      step = rows[i].s ? 8'h03 : 8'h00;
      cyc(24);
      check("active", 8'(active), 8'(rows[i].act));
      measure();
      check("on cycles", on, rows[i].on);
      check("periods", rises, rows[i].act ? (rows[i].s ? 8'h02 : 8'h08) : 8'h00);
      check("snoop", 8'(snoop), 8'h01);
    end
    resetn = 1'b0;
    auto_en = 1'b0;
    hot = 1'b0;
    ctrl = 5'h00;
    cyc(8);
    resetn = 1'b1;
    cyc(1);
    check("idle active", 8'(active), 8'h00);
    check("idle clock", 8'(clk_en), 8'h01);
    auto_en = 1'b1;
    hot = 1'b1;
    cyc(1);
    check("hot active", 8'(active), 8'h01);
    check("alert early", 8'(alert_n), 8'h01);
    cyc(1);
    check("alert", 8'(alert_n), 8'h00);
    check("irq rise", 8'(irq), 8'h01);
    cyc(1);
    check("irq pulse", 8'(irq), 8'h00);
    hot = 1'b0;
    cyc(4);
    hot = 1'b1;
    cyc(4);
    hot = 1'b0;
    cyc(7);
    check("hyst alert", 8'(alert_n), 8'h00);
    check("hyst active", 8'(active), 8'h01);
    for (int n = 0; n < 8 && alert_n !== 1'b1; n++) cyc(1);
    check("cool alert", 8'(alert_n), 8'h01);
    check("cool active", 8'(active), 8'h00);
    cyc(2);
    check("alert edges", edges, 8'h02);
    check("irq count", irqs, 8'h02);
    irq_en = 1'b0;
    hot = 1'b1;
    cyc(4);
    check("alert masked", 8'(alert_n), 8'h00);
    check("irq masked", irqs, 8'h02);
    hot = 1'b0;
    cat = 1'b1;
    cyc(1);
    cat = 1'b0;
    cyc(1);
    check("trip", 8'(trip_n), 8'h00);
    cyc(20);
    check("trip held", 8'(trip_n), 8'h00);
    resetn = 1'b0;
    cyc(8);
    resetn = 1'b1;
    cyc(1);
    check("trip cleared", 8'(trip_n), 8'h01);
    results();
  end
endmodule : tb
